// file: scs_pkg.sv
// Constants, field positions and types shared by the clock synthesizer control logic
package scs_pkg;

  // ****************************************************************
  // Programming word layout (positions within the word)
  // ****************************************************************
  localparam int WORD_W      = 16;
  localparam int BIT_N1_LO   = 1;
  localparam int BIT_N1_HI   = 4;
  localparam int BIT_RSVD    = 5;
  localparam int BIT_JAM     = 6;
  localparam int BIT_DAC     = 7;
  localparam int BIT_BYP     = 8;
  localparam int BIT_ALT     = 9;
  localparam int BIT_SHIFT_CLOCK_GATE_ENABLE    = 10;
  localparam int BIT_EXTFB   = 11;
  localparam int BIT_PDRST   = 12;
  localparam int BIT_PS_LO   = 13;
  localparam int BIT_PS_HI   = 14;
  localparam int BIT_AUXCLK  = 15;
  localparam int BIT_AUXLD   = 16;

  // Power-up word: load divider code 0001, everything else clear
  localparam logic [WORD_W:1] WORD_RESET = 16'h0001;

  // ****************************************************************
  // Divider ratios and post-scaler codes
  // ****************************************************************
  localparam int RATIO_W = 5;
  localparam int N2_W    = 9;
  localparam logic [1:0] PS_DIV1 = 2'h0;
  localparam logic [1:0] PS_DIV2 = 2'h1;
  localparam logic [1:0] PS_DIV4 = 2'h2;
  localparam logic [1:0] PS_AUX  = 2'h3;
  localparam logic [1:0] PS_CNT_DIV2 = 2'h1;
  localparam logic [1:0] PS_CNT_DIV4 = 2'h3;

  // Load divider ratio from its four-bit code; undefined code 0000 falls back to four
  function automatic logic [RATIO_W-1:0] n1_ratio(input logic [3:0] code);
    logic [RATIO_W-1:0] r;
    r = 5'h04;
    if (code[3]) begin
      case (code[1:0])
        2'h0:    r = 5'h0C;
        2'h1:    r = 5'h10;
        2'h2:    r = 5'h10;
        default: r = 5'h14;
      endcase
    end else begin
      case (code[2:0])
        3'h3:    r = 5'h05;
        3'h4:    r = 5'h06;
        3'h5:    r = 5'h08;
        3'h6:    r = 5'h08;
        3'h7:    r = 5'h0A;
        default: r = 5'h04;
      endcase
    end
    return r;
  endfunction

  // Differential clock freeze sequence; each step changes one bit except DAC_WAIT back to DAC_RUN
  typedef enum logic [1:0] {
    DAC_RUN    = 2'b00,
    DAC_FROZEN = 2'b01,
    DAC_WAIT   = 2'b11
  } scs_dac_type;

endpackage

// file: scs_div.sv
// Programmable clock divider advanced by a one-cycle step enable
`timescale 1ns/10ps
module scs_div #(
  parameter int W = 5
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Control
  input  wire logic         hold,
  input  wire logic         step,
  input  wire logic [W-1:0] ratio,
  // Divided output
  output logic              level,
  output logic              rise
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [W-1:0] cnt;
    logic         lvl;
    logic         rise;
  } scs_div_type;

  scs_div_type s_reg;
  scs_div_type s_next;
  logic [W-1:0] r_eff;
  logic [W-1:0] hi_len;

  if (W < 2) begin : g_bad_width
    $error("scs_div: W must be at least 2");
  end

  // Zero ratio acts as one so the counter never runs away
  assign r_eff  = (ratio == '0) ? W'(1) : ratio;
  // High phase takes the larger half on odd ratios
  assign hi_len = r_eff - (r_eff >> 1);

  // Next state
  always_comb begin
    s_next      = s_reg;
    s_next.rise = 1'b0;
    if (hold) begin
      s_next.cnt = '0;
      s_next.lvl = 1'b0;
    end else if (step) begin
      s_next.cnt  = (s_reg.cnt >= r_eff - W'(1)) ? '0 : s_reg.cnt + W'(1);
      s_next.lvl  = (s_next.cnt < hi_len);
      s_next.rise = (s_next.cnt == '0);
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign level = s_reg.lvl;
  assign rise  = s_reg.rise;

endmodule

// file: scs_ctrl.sv
// Control bit decoder of the serially programmed graphics clock synthesizer
//
// Behaviour
// - Load divider ratio decoded from four-bit field
// - Divider field resets to divide-by-four code
// - Loop jam tristates detector, resets counters
// - DAC reset holds positive high, negative low
// - Toggling resumes on load output rising edge
// - Reference bypass feeds reference into post-scaler
// - Alternate loop puts dividers into feedback
// - Shift clock enable lets blanking gate output
// - External feedback select uses feedback pin
// - Detector reset enable: blanking disables locking
// - Post-scaler code 01 halves the loop frequency
// - Auxiliary mode: load bit drives load output
// - Load bit outside auxiliary mode gives F/2
// - Second divider always clocked from load output
`timescale 1ns/10ps
module scs_ctrl
  import scs_pkg::*;
(
  // Clock and reset (clock is the synthesized loop clock)
  input  wire logic              REF_CLK,
  input  wire logic              RSTN,
  // Programming word from the serial shifter
  input  wire logic [WORD_W:1]   CFG_WORD,
  input  wire logic              CFG_LOAD,
  input  wire logic [N2_W-1:0]   SECOND_DIV_RATIO,
  // Pins from outside the clock domain
  input  wire logic              BLANK_PIN,
  input  wire logic              EXTERNAL_FEEDBACK_PIN,
  input  wire logic              REFERENCE_IN,
  // Internal feedback from the loop counter chain
  input  wire logic              INTERNAL_FEEDBACK,
  // Clock outputs
  output logic                   CLK_POS,
  output logic                   CLK_NEG,
  output logic                   LOAD_CLOCK_OUTPUT,
  output logic                   SECOND_DIVIDED_OUTPUT,
  // Loop control outputs
  output logic                   DETECTOR_OE_N,
  output logic                   COUNTER_RESET,
  output logic                   LOCK_DISABLE,
  output logic                   PFD_FEEDBACK,
  output logic                   REFERENCE_BYPASS,
  output logic [RATIO_W-1:0]     LOAD_RATIO
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic [WORD_W:1]     w;
    logic                loaded;
    logic [2:0]          blank_sy;
    logic                blank_f;
    logic [2:0]          efb_sy;
    logic                efb_f;
    logic [2:0]          ref_sy;
    logic                ref_f;
    logic [1:0]          ps_cnt;
    logic                pix_tog;
    logic                half_tog;
    scs_dac_type         st;
    logic                clk_pos;
    logic                clk_neg;
    logic                load_out;
    logic                load_rise;
    logic                second_out;
    logic                oe_n;
    logic                cnt_rst;
    logic                lock_dis;
    logic                pfd_fb;
    logic                ref_byp;
    logic [RATIO_W-1:0]  ratio;
  } scs_ctrl_type;

  scs_ctrl_type s_reg;
  scs_ctrl_type s_next;

  // Decoded fields
  logic       jam;
  logic       dac;
  logic       aux;
  logic [1:0] ps;
  logic       ref_rise;
  logic       base_en;
  logic       pix_en;
  logic       load_div_lvl;
  logic       sec_lvl;

  if (WORD_W != 16) begin : g_bad_word
    $error("scs_ctrl: programming word must be 16 bits");
  end

  // Bit five is left alone; the host keeps it at zero
  assign jam = s_reg.w[BIT_JAM];
  assign dac = s_reg.w[BIT_DAC];
  assign ps  = s_reg.w[BIT_PS_HI:BIT_PS_LO];
  assign aux = (ps == PS_AUX);
  assign ref_rise = ~s_reg.ref_f & s_reg.ref_sy[2] & s_reg.ref_sy[1]; // Filtered level rises

  // ****************************************************************
  // Post-scaler time base
  // ****************************************************************
  // Reference replaces the loop clock as post-scaler input
  assign base_en = s_reg.w[BIT_BYP] ? ref_rise : 1'b1;
  always_comb begin
    case (ps)
      PS_DIV1: pix_en = base_en;
      PS_DIV2: pix_en = base_en && (s_reg.ps_cnt[0] == PS_CNT_DIV2[0]);
      PS_DIV4: pix_en = base_en && (s_reg.ps_cnt == PS_CNT_DIV4);
      default: pix_en = 1'b0;
    endcase
  end

  // ****************************************************************
  // Dividers
  // ****************************************************************
  // Load divider counts pixel periods at the decoded ratio
  scs_div #(.W(RATIO_W)) u_load_div (
    .clk   (REF_CLK),
    .rst_n (RSTN),
    .hold  (1'b0),
    .step  (pix_en),
    .ratio (s_reg.ratio),
    .level (load_div_lvl),
    .rise  ()
  );

  // Second divider follows the load output, held while the loop is jammed
  scs_div #(.W(N2_W)) u_second_div (
    .clk   (REF_CLK),
    .rst_n (RSTN),
    .hold  (jam),
    .step  (s_reg.load_rise),
    .ratio (SECOND_DIV_RATIO),
    .level (sec_lvl),
    .rise  ()
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    s_next = s_reg;
    // Word is written whole so decoded functions never see a half update
    if (CFG_LOAD) begin
      s_next.w      = CFG_WORD;
      s_next.loaded = 1'b1;
    end
    // Three-stage synchronisers; a change counts when stages two and three agree
    s_next.blank_sy = {s_reg.blank_sy[1:0], BLANK_PIN};
    s_next.efb_sy   = {s_reg.efb_sy[1:0], EXTERNAL_FEEDBACK_PIN};
    s_next.ref_sy   = {s_reg.ref_sy[1:0], REFERENCE_IN};
    if (s_reg.blank_sy[1] == s_reg.blank_sy[2]) s_next.blank_f = s_reg.blank_sy[2];
    if (s_reg.efb_sy[1] == s_reg.efb_sy[2])     s_next.efb_f   = s_reg.efb_sy[2];
    if (s_reg.ref_sy[1] == s_reg.ref_sy[2])     s_next.ref_f   = s_reg.ref_sy[2];

    if (base_en) s_next.ps_cnt = s_reg.ps_cnt + 2'h1;
    s_next.half_tog = ~s_reg.half_tog;
    s_next.ratio    = n1_ratio(s_reg.w[BIT_N1_HI:BIT_N1_LO]);

    // Load output source: auxiliary bit, F/2 override, or load divider
    if (aux) begin
      s_next.load_out = s_reg.w[BIT_AUXLD];
    end else if (s_reg.w[BIT_AUXLD]) begin
      s_next.load_out = s_reg.half_tog;
    end else begin
      s_next.load_out = load_div_lvl;
    end
    s_next.load_rise = s_next.load_out & ~s_reg.load_out;

    // Differential clock freeze and resume
    if (pix_en) s_next.pix_tog = ~s_reg.pix_tog;
    case (s_reg.st)
      DAC_RUN:    s_next.st = DAC_RUN;
      DAC_FROZEN: s_next.st = DAC_WAIT;
      DAC_WAIT: begin
        if (s_reg.load_rise) begin
          s_next.st      = DAC_RUN;
          s_next.pix_tog = 1'b1;
        end
      end
      default: s_next.st = DAC_FROZEN;
    endcase
    if (dac) s_next.st = DAC_FROZEN;
    // Freeze beats everything; the load and second outputs keep running
    if (s_next.st != DAC_RUN) begin
      s_next.clk_pos = 1'b1;
      s_next.clk_neg = 1'b0;
    end else if (aux) begin
      s_next.clk_pos = s_reg.w[BIT_AUXCLK];
      s_next.clk_neg = ~s_reg.w[BIT_AUXCLK];
    end else begin
      s_next.clk_pos = s_next.pix_tog;
      s_next.clk_neg = ~s_next.pix_tog;
    end

    // Blanking gates the second output only when enabled
    s_next.second_out = sec_lvl & ~(s_reg.w[BIT_SHIFT_CLOCK_GATE_ENABLE] & s_reg.blank_f);

    // Loop control
    s_next.oe_n     = jam;
    s_next.cnt_rst  = jam;
    s_next.lock_dis = jam | (s_reg.w[BIT_PDRST] & s_reg.blank_f);
    s_next.ref_byp  = s_reg.w[BIT_BYP];
    if (s_reg.w[BIT_EXTFB]) begin
      s_next.pfd_fb = s_reg.efb_f;
    end else if (s_reg.w[BIT_ALT]) begin
      s_next.pfd_fb = sec_lvl;
    end else begin
      s_next.pfd_fb = INTERNAL_FEEDBACK;
    end
  end

  // State register; word comes up at the divide-by-four code
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      s_reg         <= '0;
      s_reg.w       <= WORD_RESET;
      s_reg.st      <= DAC_RUN;
      s_reg.clk_neg <= 1'b1;
      s_reg.ratio   <= 5'h04;
    end else begin
      s_reg <= s_next;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign CLK_POS               = s_reg.clk_pos;
  assign CLK_NEG               = s_reg.clk_neg;
  assign LOAD_CLOCK_OUTPUT     = s_reg.load_out;
  assign SECOND_DIVIDED_OUTPUT = s_reg.second_out;
  assign DETECTOR_OE_N         = s_reg.oe_n;
  assign COUNTER_RESET         = s_reg.cnt_rst;
  assign LOCK_DISABLE          = s_reg.lock_dis;
  assign PFD_FEEDBACK          = s_reg.pfd_fb;
  assign REFERENCE_BYPASS      = s_reg.ref_byp;
  assign LOAD_RATIO            = s_reg.ratio;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  property p_ratio_ten;
    @(posedge REF_CLK) disable iff (!RSTN)
    (s_reg.w[BIT_N1_HI:BIT_N1_LO] == 4'h7) |=> (LOAD_RATIO == 5'h0A);
  endproperty
  a_ratio_ten: assert property (p_ratio_ten) else $error("ratio not ten");
  property p_reset_word;
    @(posedge REF_CLK) disable iff (!RSTN)
    !s_reg.loaded |-> (s_reg.w[BIT_N1_HI:BIT_N1_LO] == 4'h1);
  endproperty
  a_reset_word: assert property (p_reset_word) else $error("bad power-up code");
  property p_jam;
    @(posedge REF_CLK) disable iff (!RSTN)
    jam |=> (DETECTOR_OE_N && COUNTER_RESET && LOCK_DISABLE);
  endproperty
  a_jam: assert property (p_jam) else $error("jam not applied");
  property p_dac_hold;
    @(posedge REF_CLK) disable iff (!RSTN)
    dac |=> (CLK_POS && !CLK_NEG);
  endproperty
  a_dac_hold: assert property (p_dac_hold) else $error("clock not frozen");
  property p_wait_load;
    @(posedge REF_CLK) disable iff (!RSTN)
    (s_reg.st == DAC_WAIT && !dac && !s_reg.load_rise) |=> (CLK_POS && s_reg.st == DAC_WAIT);
  endproperty
  a_wait_load: assert property (p_wait_load) else $error("resumed early");
  property p_bypass_hold;
    @(posedge REF_CLK) disable iff (!RSTN)
    (s_reg.w[BIT_BYP] && !ref_rise && !aux && s_reg.st == DAC_RUN && !dac) |=> $stable(CLK_POS);
  endproperty
  a_bypass_hold: assert property (p_bypass_hold) else $error("toggle without ref");
  property p_ext_fb;
    @(posedge REF_CLK) disable iff (!RSTN)
    s_reg.w[BIT_EXTFB] |=> (PFD_FEEDBACK == $past(s_reg.efb_f));
  endproperty
  a_ext_fb: assert property (p_ext_fb) else $error("feedback not from pin");
  property p_gate;
    @(posedge REF_CLK) disable iff (!RSTN)
    (s_reg.w[BIT_SHIFT_CLOCK_GATE_ENABLE] && s_reg.blank_f) |=> !SECOND_DIVIDED_OUTPUT;
  endproperty
  a_gate: assert property (p_gate) else $error("second output not gated");
  property p_override;
    @(posedge REF_CLK) disable iff (!RSTN)
    (!aux && s_reg.w[BIT_AUXLD]) ##1 (!aux && s_reg.w[BIT_AUXLD])
      |=> (LOAD_CLOCK_OUTPUT != $past(LOAD_CLOCK_OUTPUT));
  endproperty
  a_override: assert property (p_override) else $error("load not at F/2");

endmodule

// file: scs_host_model.sv
// Host controller model that presents whole programming words to the control decoder
`timescale 1ns/10ps
module scs_host_model
  import scs_pkg::*;
(
  // Clock
  input  wire logic         clk,
  // Programming word toward the block
  output logic [WORD_W:1]   cfg_word,
  output logic              cfg_load
);
  // ****************************************************************
  // Word transfer
  // ****************************************************************
  // Idle bus shows no stale word, so a decoder reading it outside the strobe is caught
  initial begin
    cfg_word = ~WORD_RESET;
    cfg_load = 1'b0;
  end

  // One-cycle load strobe launched on a falling edge, whole word at once
  task automatic send(input logic [WORD_W:1] w);
    logic [WORD_W:1] v;
    v           = w;
    v[BIT_RSVD] = 1'b0;                 // Reserved bit forced clear
    @(negedge clk);
    cfg_word = v;
    cfg_load = 1'b1;
    @(negedge clk);
    cfg_load = 1'b0;
    cfg_word = ~v;
  endtask
endmodule

// file: tb_top.sv
// Self-checking testbench of the clock synthesizer control decoder
`timescale 1ns/10ps
module tb_top
  import scs_pkg::*;
;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic                 ref_clk;
  logic                 rstn;
  logic [WORD_W:1]      cfg_word;
  logic                 cfg_load;
  logic                 blank;
  logic                 ext_fb;
  logic                 ref_in;
  logic                 int_fb;
  logic                 clk_pos;
  logic                 clk_neg;
  logic                 load_out;
  logic                 second_out;
  logic                 det_oe_n;
  logic                 cnt_rst;
  logic                 lock_dis;
  logic                 pfd_fb;
  logic                 byp;
  logic [RATIO_W-1:0]   ratio;
  int                   err_total;
  int                   num_checks;
  int                   pc;
  int                   lc;
  int                   sc;
  int                   i;
  logic                 seen;
  logic                 lp;
  // Expected ratio per divider code, five bits each, code fifteen first
  localparam logic [79:0] RT = {5'h14, 5'h10, 5'h10, 5'h0C, 5'h14, 5'h10, 5'h10, 5'h0C,
                                5'h0A, 5'h08, 5'h08, 5'h06, 5'h05, 5'h04, 5'h04, 5'h04};

  scs_host_model host_u (
    .clk      (ref_clk),
    .cfg_word (cfg_word),
    .cfg_load (cfg_load)
  );

  scs_ctrl dut_u (
    .REF_CLK               (ref_clk),
    .RSTN                  (rstn),
    .CFG_WORD              (cfg_word),
    .CFG_LOAD              (cfg_load),
    .SECOND_DIV_RATIO      (9'h002),
    .BLANK_PIN             (blank),
    .EXTERNAL_FEEDBACK_PIN (ext_fb),
    .REFERENCE_IN          (ref_in),
    .INTERNAL_FEEDBACK     (int_fb),
    .CLK_POS               (clk_pos),
    .CLK_NEG               (clk_neg),
    .LOAD_CLOCK_OUTPUT     (load_out),
    .SECOND_DIVIDED_OUTPUT (second_out),
    .DETECTOR_OE_N         (det_oe_n),
    .COUNTER_RESET         (cnt_rst),
    .LOCK_DISABLE          (lock_dis),
    .PFD_FEEDBACK          (pfd_fb),
    .REFERENCE_BYPASS      (byp),
    .LOAD_RATIO            (ratio)
  );

  // ****************************************************************
  // Clock, slow reference and helpers
  // ****************************************************************
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  // Reference runs at one eighth of the loop clock, changed on falling edges
  initial begin
    ref_in = 1'b0;
    forever begin
      repeat (4) @(negedge ref_clk);
      ref_in <= ~ref_in;
    end
  end

  function automatic logic [WORD_W:1] b(input int n);
    logic [WORD_W:1] v;
    v    = '0;
    v[n] = 1'b1;
    return v;
  endfunction

  task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Store a word, then let the decode latency pass and the dividers settle on it
  task automatic wr(input logic [WORD_W:1] w);
    host_u.send(w);
    repeat (4) @(negedge ref_clk);
  endtask

  // Count output changes over n falling edges
  task automatic cnt(input int n, output int p, output int l, output int s);
    logic a;
    logic c;
    logic d;
    p = 0;
    l = 0;
    s = 0;
    a = clk_pos;
    c = load_out;
    d = second_out;
    repeat (n) begin
      @(negedge ref_clk);
      if (clk_pos !== a) p++;
      if (load_out !== c) l++;
      if (second_out !== d) s++;
      a = clk_pos;
      c = load_out;
      d = second_out;
    end
  endtask

  task automatic test_done();
    $display("Checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    err_total  = 0;
    num_checks = 0;
    rstn       = 1'b0;
    blank      = 1'b0;
    ext_fb     = 1'b0;
    int_fb     = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk("reset_ratio", 16'h0004, ratio);
    chk("reset_clk_pos", 16'h0000, clk_pos);
    chk("reset_clk_neg", 16'h0001, clk_neg);
    rstn = 1'b1;
    // Every divider code, top bit clear and set
    for (i = 0; i < 16; i++) begin
      wr(WORD_RESET & ~16'h000F | 16'(i));
      chk("load_ratio", 16'(RT[i*5 +: 5]), ratio);
    end
    wr(WORD_RESET);
    cnt(20, pc, lc, sc);
    chk("pix_rate_div1", 16'd20, pc);
    chk("load_rate_div4", 16'd10, lc);
    // Jam holds detector and counters
    wr(WORD_RESET | b(BIT_JAM));
    chk("jam_oe_n", 16'h0001, det_oe_n);
    chk("jam_cnt_rst", 16'h0001, cnt_rst);
    wr(WORD_RESET);
    chk("unjam_oe_n", 16'h0000, det_oe_n);
    chk("unjam_cnt_rst", 16'h0000, cnt_rst);
    // Pipeline reset: one then zero, other functions keep running
    wr(WORD_RESET | b(BIT_DAC));
    cnt(20, pc, lc, sc);
    chk("dac_pos_hi", 16'h0001, clk_pos);
    chk("dac_neg_lo", 16'h0000, clk_neg);
    chk("dac_frozen", 16'd0, pc);
    chk("dac_load_runs", 16'd10, lc);
    host_u.send(WORD_RESET);
    seen = 1'b0;
    lp   = load_out;
    i    = 0;
    // Resume must follow a fresh rising edge of the load output
    while (clk_pos === 1'b1 && i < 200) begin
      @(negedge ref_clk);
      if (load_out === 1'b1 && lp === 1'b0) seen = 1'b1;
      lp = load_out;
      i++;
    end
    if (i >= 200) begin
      err_total++;
      $display("MISMATCH dac_resume expected toggle seen none");
      test_done();
    end
    chk("dac_resume_after_load", 16'h0001, seen);
    // Post-scaler rates and auxiliary load override
    wr(WORD_RESET | 16'(PS_DIV2) << (BIT_PS_LO-1));
    cnt(20, pc, lc, sc);
    chk("pix_rate_div2", 16'd10, pc);
    chk("load_rate_div2", 16'd5, lc);
    wr(WORD_RESET | 16'(PS_DIV4) << (BIT_PS_LO-1));
    cnt(20, pc, lc, sc);
    chk("pix_rate_div4", 16'd5, pc);
    wr(WORD_RESET | b(BIT_AUXLD));
    cnt(20, pc, lc, sc);
    chk("load_half_rate", 16'd20, lc);
    // Auxiliary mode drives outputs from the stored bits
    wr(WORD_RESET | 16'(PS_AUX) << (BIT_PS_LO-1) | b(BIT_AUXCLK) | b(BIT_AUXLD));
    chk("aux_pos_hi", 16'h0001, clk_pos);
    chk("aux_neg_lo", 16'h0000, clk_neg);
    chk("aux_load_hi", 16'h0001, load_out);
    wr(WORD_RESET | 16'(PS_AUX) << (BIT_PS_LO-1));
    chk("aux_pos_lo", 16'h0000, clk_pos);
    chk("aux_neg_hi", 16'h0001, clk_neg);
    chk("aux_load_lo", 16'h0000, load_out);
    // Reference bypass: pixel clock paced by reference edges
    wr(WORD_RESET | b(BIT_BYP));
    chk("bypass_flag", 16'h0001, byp);
    cnt(40, pc, lc, sc);
    chk("bypass_rate", 16'h0001, 16'(pc >= 4 && pc <= 6));
    // Feedback source selection
    ext_fb = 1'b1;
    wr(WORD_RESET | b(BIT_EXTFB));
    repeat (6) @(negedge ref_clk);
    chk("ext_fb_hi", 16'h0001, pfd_fb);
    ext_fb = 1'b0;
    int_fb = 1'b1;
    repeat (6) @(negedge ref_clk);
    chk("ext_fb_lo", 16'h0000, pfd_fb);
    // Alternate loop: feedback follows the second divider, not the held-high internal input
    wr(WORD_RESET | b(BIT_ALT));
    seen = 1'b0;
    lp   = 1'b0;
    repeat (16) begin
      @(negedge ref_clk);
      if (pfd_fb === 1'b0) seen = 1'b1;
      if (pfd_fb === 1'b1) lp = 1'b1;
    end
    chk("alt_fb_low", 16'h0001, seen);
    chk("alt_fb_high", 16'h0001, lp);
    wr(WORD_RESET);
    repeat (6) @(negedge ref_clk);
    chk("int_fb", 16'h0001, pfd_fb);
    // Blanking gates locking only when enabled
    blank = 1'b1;
    wr(WORD_RESET | b(BIT_PDRST));
    repeat (6) @(negedge ref_clk);
    chk("blank_lock_dis", 16'h0001, lock_dis);
    wr(WORD_RESET);
    chk("blank_no_lock_dis", 16'h0000, lock_dis);
    // Blanking gates the second divided output only when enabled
    wr(WORD_RESET | b(BIT_SHIFT_CLOCK_GATE_ENABLE));
    repeat (6) @(negedge ref_clk);
    cnt(40, pc, lc, sc);
    chk("blank_gates_second", 16'd0, sc);
    wr(WORD_RESET);
    cnt(40, pc, lc, sc);
    chk("second_runs", 16'h0001, 16'(sc > 0));
    blank = 1'b0;
    test_done();
  end
endmodule
